// [pkg/scfd_regs.svh]
`ifndef SCFD_REGS_SVH
`define SCFD_REGS_SVH
`define SCFD_FRAME_BITS 16
`define SCFD_TYPE_HI 15
`define SCFD_TYPE_LO 14
`define SCFD_ADDR_HI 13
`define SCFD_ADDR_LO 9
`define SCFD_PAR_BIT 8
`define SCFD_SUB_BIT 7
`define SCFD_ADDR_AMON 5'h00
`define SCFD_AMON_RESET 8'h00
`define SCFD_AMON_SEL_HI 7
`define SCFD_AMON_SEL_LO 5
`define SCFD_AMON_RES_BIT 4
`define SCFD_AMON_ATT_BIT 3
`define SCFD_AMON_WMASK 8'hf8
`define SCFD_PARITY_EN_BIT 6
`endif

// [pkg/scfd_pkg.sv]
package scfd_pkg;
  typedef enum logic [1:0]
  {
    SCFD_CMD_READ = 2'h0,
    SCFD_CMD_WRITE = 2'h1,
    SCFD_CMD_RSVD = 2'h2,
    SCFD_CMD_FLAGS = 2'h3
  } scfd_cmd_e;
  typedef enum logic [2:0]
  {
    SCFD_MON_OFF = 3'h0,
    SCFD_MON_REG_CURRENT = 3'h1,
    SCFD_MON_VREF = 3'h2,
    SCFD_MON_TEMP = 3'h3,
    SCFD_MON_IO0 = 3'h4,
    SCFD_MON_IO1 = 3'h5,
    SCFD_MON_SUPPLY = 3'h6,
    SCFD_MON_SENSE = 3'h7
  } scfd_mon_e;
endpackage : scfd_pkg

// [rtl/scfd_amon_sel.sv]
`timescale 1ns/10ps
`include "scfd_regs.svh"
module scfd_amon_sel
(
  input wire logic [7:0] reg_value,
  output logic [7:0] source_onehot,
  output logic monitor_enable,
  output logic resistor_enable,
  output logic attenuate
);
  wire logic [2:0] sel;
  assign sel = reg_value[`SCFD_AMON_SEL_HI:`SCFD_AMON_SEL_LO];
  // code 000 drives no source and clears monitor_enable; resistor and attenuate bits still pass
  assign monitor_enable = (sel != scfd_pkg::SCFD_MON_OFF); // RL13
  assign resistor_enable = reg_value[`SCFD_AMON_RES_BIT];
  assign attenuate = reg_value[`SCFD_AMON_ATT_BIT];
  // bit n high selects source code n; bit 0 unused (off)
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_src
      assign source_onehot[g] = (g != 0) && (sel == 3'(g)); // RL15
    end
  endgenerate
endmodule : scfd_amon_sel

// [rtl/scfd_frame_decoder.sv]
`timescale 1ns/10ps
`include "scfd_regs.svh"
// Overview of operation
// RL1: frame is type[15:14], address[13:9], parity/next[8], data[7:0].
// RL2: type 00 read: status byte then addressed register control bits.
// RL3: read with bit 7 set returns status then id and I/O states.
// RL4: type 01 write stores data, returns fixed then extended status.
// RL5: type 11 reads flags; bit 7 picks low or high flag group.
// RL6: flag read returns status byte then selected flags.
// RL7: parity counts ones over bits 15..9 and 7..0 on writes.
// RL8: host sets bit 8 to one when counted ones are even.
// RL9: parity check active only when misc init bit 6 set.
// RL10: host drives bit 8 low when parity disabled.
// RL11: monitor register: selector 7:5, resistor 4, attenuate 3, 2:0 zero.
// RL12: monitor register clears at reset, regulator off, or non-normal mode.
// RL13: selector 000 disables every monitor function. Code still drives resistor 4 and attenuate 3 at 000.
// RL14: monitor access with regulator off ignored, register cleared.
// RL15: selector codes 001..111 pick the seven monitored sources in order.
// RL16: write with bad parity under enabled parity is discarded.
// RL17: one 16-bit frame, msb first, per chip select, miso shifted alongside.
module scfd_frame_decoder
#(
  parameter int FRAME_BITS = `SCFD_FRAME_BITS
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck_rise,
  input wire logic sck_fall,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe_n,
  input wire logic [7:0] fixed_status,
  input wire logic [7:0] extended_status,
  input wire logic [7:0] id_io_state,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] flags_rdata,
  input wire logic [7:0] misc_init,
  input wire logic can_reg_on,
  input wire logic normal_mode,
  output logic [4:0] reg_addr,
  output logic flag_sub_high,
  output logic wr_strobe,
  output logic [7:0] wr_data,
  output logic flag_rd_strobe,
  output logic parity_error,
  output logic [7:0] analog_monitor_register,
  output logic [7:0] amon_source,
  output logic amon_enable,
  output logic internal_resistor_enable,
  output logic amon_attenuate
);
  ////////////////////////////////////////////////////////////////////////////
  // frame capture; sck edges arrive as one-cycle strobes in clock domain
  logic [15:0] sh_q;
  logic [4:0] cnt_q;
  logic [7:0] tx_q;
  logic cs_q;
  logic [7:0] amon_q;
  logic [7:0] wdata_q;
  logic wr_q, frd_q, perr_q, sub_q;
  logic [4:0] addr_q;
  wire logic cs_act = ~cs_n;
  wire logic [15:0] frame_d = {sh_q[14:0], mosi};
  wire logic take = cs_act && sck_rise && (cnt_q < 5'(FRAME_BITS)); // RL17
  wire logic frame_end = cs_q && !cs_act && (cnt_q == 5'(FRAME_BITS));
  ////////////////////////////////////////////////////////////////////////////
  // field decode
  wire logic [1:0] f_type = sh_q[`SCFD_TYPE_HI:`SCFD_TYPE_LO]; // RL1
  wire logic [4:0] f_addr = sh_q[`SCFD_ADDR_HI:`SCFD_ADDR_LO]; // RL1
  wire logic f_par = sh_q[`SCFD_PAR_BIT];
  wire logic [7:0] f_data = sh_q[7:0];
  // bit 8 must equal one when the rest holds an even count
  wire logic par_exp = ~(^{f_type, f_addr, f_data}); // RL7 RL8
  wire logic par_en = misc_init[`SCFD_PARITY_EN_BIT]; // RL9
  wire logic par_bad = par_en && (f_par != par_exp); // RL16
  wire logic is_write = (f_type == scfd_pkg::SCFD_CMD_WRITE);
  wire logic is_flags = (f_type == scfd_pkg::SCFD_CMD_FLAGS);
  wire logic hit_amon = (f_addr == `SCFD_ADDR_AMON);
  ////////////////////////////////////////////////////////////////////////////
  // miso: fixed status during first byte, chosen byte after bit 8 is in
  // second byte depends on bit 7 of mosi, so chosen as bit 7 is sampled, at count 8
  logic [7:0] second_d;
  always_comb
  begin
    second_d = 8'h00;
    case (scfd_pkg::scfd_cmd_e'(sh_q[7:6]))
      scfd_pkg::SCFD_CMD_READ: second_d = reg_rdata;
      scfd_pkg::SCFD_CMD_WRITE: second_d = extended_status; // RL4
      scfd_pkg::SCFD_CMD_FLAGS: second_d = flags_rdata; // RL6
      default: second_d = 8'h00;
    endcase
  end
  // at count 8 shift register holds the first eight bits: type at [7:6]
  wire logic [7:0] amon_rd =
    can_reg_on ? amon_q : `SCFD_AMON_RESET; // RL14
  wire logic rd_amon = (sh_q[7:6] == scfd_pkg::SCFD_CMD_READ)
    && (sh_q[5:1] == `SCFD_ADDR_AMON);
  wire logic [7:0] second_sel = rd_amon ? amon_rd : second_d;
  // bit 7 of mosi arrives at count 8; id byte needs it, so it is
  // resolved there, before the first second-byte bit is sampled
  wire logic load_second = take && (cnt_q == 5'd8);
  wire logic [7:0] id_pick =
    (sh_q[7:6] == scfd_pkg::SCFD_CMD_READ && mosi) ? id_io_state // RL3
      : second_sel; // RL2
  ////////////////////////////////////////////////////////////////////////////
  // monitor register next value
  logic [7:0] amon_d;
  always_comb
  begin
    amon_d = amon_q;
    if (!can_reg_on || !normal_mode)
    begin
      amon_d = `SCFD_AMON_RESET; // RL12 RL14
    end
    else if (frame_end && is_write && hit_amon && !par_bad)
    begin
      amon_d = f_data & `SCFD_AMON_WMASK; // RL11 RL16
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sh_q <= 16'h0000;
      cnt_q <= 5'h00;
      tx_q <= 8'h00;
      cs_q <= 1'b0;
      amon_q <= `SCFD_AMON_RESET; // RL12
      wr_q <= 1'b0;
      frd_q <= 1'b0;
      perr_q <= 1'b0;
      wdata_q <= 8'h00;
      addr_q <= 5'h00;
      sub_q <= 1'b0;
    end
    else
    begin
      cs_q <= cs_act;
      amon_q <= amon_d;
      if (!cs_act)
      begin
        cnt_q <= 5'h00;
        tx_q <= fixed_status; // RL2 RL4 RL6
      end
      else
      begin
        if (take)
        begin
          sh_q <= frame_d;
          cnt_q <= cnt_q + 5'd1;
        end
        if (load_second)
        begin
          tx_q <= id_pick;
        end
        else if (sck_fall)
        begin
          tx_q <= {tx_q[6:0], 1'b0}; // RL17
        end
      end
      wr_q <= frame_end && is_write && !par_bad; // RL16
      perr_q <= frame_end && is_write && par_bad;
      frd_q <= frame_end && is_flags; // RL5
      if (frame_end)
      begin
        wdata_q <= f_data;
        addr_q <= f_addr;
        sub_q <= sh_q[`SCFD_SUB_BIT]; // RL5
      end
    end
  end
  assign miso = tx_q[7];
  assign miso_oe_n = ~cs_act;
  assign wr_strobe = wr_q;
  assign wr_data = wdata_q;
  assign reg_addr = addr_q;
  assign flag_sub_high = sub_q;
  assign flag_rd_strobe = frd_q;
  assign parity_error = perr_q;
  assign analog_monitor_register = amon_q;
  ////////////////////////////////////////////////////////////////////////////
  scfd_amon_sel u_sel
  (
    .reg_value(amon_q),
    .source_onehot(amon_source),
    .monitor_enable(amon_enable),
    .resistor_enable(internal_resistor_enable),
    .attenuate(amon_attenuate)
  );
  ////////////////////////////////////////////////////////////////////////////
  id_byte_a: assert property (@(posedge clock) disable iff (rst)
    load_second && sh_q[7:6] == 2'b00 && mosi |=> tx_q == $past(id_io_state))
    else $error("id byte missing"); // RL3
  ////////////////////////////////////////////////////////////////////////////
  low_bits_a: assert property (@(posedge clock) disable iff (rst)
    amon_q[2:0] == 3'h0) else $error("monitor low bits set"); // RL11
  off_clear_a: assert property (@(posedge clock) disable iff (rst)
    !can_reg_on |=> amon_q == 8'h00) else $error("monitor kept"); // RL12
  mode_clear_a: assert property (@(posedge clock) disable iff (rst)
    !normal_mode |=> amon_q == 8'h00) else $error("mode kept"); // RL12
  bad_par_a: assert property (@(posedge clock) disable iff (rst)
    frame_end && is_write && par_bad |=> !wr_q && perr_q)
    else $error("bad parity wrote"); // RL16
  good_wr_a: assert property (@(posedge clock) disable iff (rst)
    frame_end && is_write && !par_bad |=> wr_q && wdata_q == $past(f_data))
    else $error("write lost"); // RL4
  amon_wr_a: assert property (@(posedge clock) disable iff (rst)
    frame_end && is_write && hit_amon && !par_bad && can_reg_on
    && normal_mode |=> amon_q == ($past(f_data) & 8'hf8))
    else $error("monitor write lost"); // RL11
  sel_off_a: assert property (@(posedge clock) disable iff (rst)
    amon_q[7:5] == 3'h0 |-> !amon_enable && amon_source == 8'h00)
    else $error("monitor on at 000"); // RL13
  flag_rd_a: assert property (@(posedge clock) disable iff (rst)
    frame_end && is_flags |=> frd_q && sub_q == $past(sh_q[7]))
    else $error("flag read lost"); // RL5
  idle_tx_a: assert property (@(posedge clock) disable iff (rst)
    !cs_act |=> miso == $past(fixed_status[7]))
    else $error("status msb missing"); // RL17
endmodule : scfd_frame_decoder

// [tb/scfd_host_model.sv]
`timescale 1ns/10ps
module scfd_host_model
(
  input wire logic clock,
  input wire logic miso,
  output logic cs_n,
  output logic sck_rise,
  output logic sck_fall,
  output logic mosi
);
  initial
  begin
    cs_n = 1'b1;
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    mosi = 1'b0;
  end
  //////////////////////////////
  // whole frame, msb first, miso taken while the fall pulse is up
  task automatic xfer(input logic [15:0] c, output logic [15:0] r);
    @(posedge clock) #1 cs_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      @(posedge clock) #1 mosi = c[i];
      sck_rise = 1'b1;
      @(posedge clock) #1 sck_rise = 1'b0;
      sck_fall = 1'b1;
      r[i] = miso;
      @(posedge clock) #1 sck_fall = 1'b0;
    end
    @(posedge clock) #1 cs_n = 1'b1;
    // stale data must not look valid between frames
    mosi = ~mosi;
    repeat (3) @(posedge clock);
    #1;
  endtask : xfer
endmodule : scfd_host_model

// [tb/test_spi_command_frame_decoder.sv]
`timescale 1ns/10ps
module test_spi_command_frame_decoder;
  logic clock, rst, cs_n, sck_rise, sck_fall, mosi, miso, miso_oe_n;
  logic [7:0] fixed_status, extended_status, id_io_state, reg_rdata;
  logic [7:0] flags_rdata, misc_init, wr_data, amr, amon_source;
  logic can_reg_on, normal_mode, flag_sub_high, wr_strobe, flag_rd_strobe;
  logic parity_error, amon_enable, res_en, amon_attenuate;
  logic [4:0] reg_addr;
  logic [15:0] r;
  int failures, n_checks, n_wr, n_fl, n_pe;
  scfd_frame_decoder dut
  (
    .clock(clock), .rst(rst), .cs_n(cs_n), .sck_rise(sck_rise),
    .sck_fall(sck_fall), .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n),
    .fixed_status(fixed_status), .extended_status(extended_status),
    .id_io_state(id_io_state), .reg_rdata(reg_rdata),
    .flags_rdata(flags_rdata), .misc_init(misc_init),
    .can_reg_on(can_reg_on), .normal_mode(normal_mode),
    .reg_addr(reg_addr), .flag_sub_high(flag_sub_high),
    .wr_strobe(wr_strobe), .wr_data(wr_data),
    .flag_rd_strobe(flag_rd_strobe), .parity_error(parity_error),
    .analog_monitor_register(amr), .amon_source(amon_source),
    .amon_enable(amon_enable), .internal_resistor_enable(res_en),
    .amon_attenuate(amon_attenuate)
  );
  scfd_host_model host
  (
    .clock(clock), .miso(miso), .cs_n(cs_n), .sck_rise(sck_rise),
    .sck_fall(sck_fall), .mosi(mosi)
  );
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // strobes last one cycle, so they are counted rather than polled
  always @(posedge clock)
  begin
    n_wr += wr_strobe;
    n_fl += flag_rd_strobe;
    n_pe += parity_error;
  end
  //////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic p);
    host.xfer({2'b01, a, p, d}, r);
    chk("write status", {fixed_status, extended_status}, r);
    chk("write data", 16'({a, d}), 16'({reg_addr, wr_data}));
  endtask : wr
  function automatic logic par(input logic [15:0] c);
    return ~^{c[15:9], c[7:0]};
  endfunction : par
  task automatic complete_run;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (20000) @(posedge clock);
    failures++;
    complete_run();
  end
  //////////////////////////////
  initial
  begin
    rst = 1'b1;
    fixed_status = 8'ha5;
    extended_status = 8'h3c;
    id_io_state = 8'h96;
    reg_rdata = 8'h5a;
    flags_rdata = 8'h69;
    misc_init = 8'h00;
    can_reg_on = 1'b1;
    normal_mode = 1'b1;
    repeat (3) @(posedge clock);
    #1 rst = 1'b0;
    chk("reset value", 16'h0000, 16'(amr));
    chk("oe idle", 16'h0001, 16'(miso_oe_n));
    wr(5'h00, 8'hff, 1'b0);
    chk("monitor mask", 16'h00f8, 16'(amr));
    chk("res att", 16'h0003, 16'({res_en, amon_attenuate}));
    for (int c = 0; c < 8; c++)
    begin
      wr(5'h00, {3'(c), 5'h10}, 1'b0);
      chk("source", 16'(c ? 1 << c : 0), 16'(amon_source));
      chk("enable", 16'(c != 0), 16'(amon_enable));
    end
    $display("test monitor write done");
    host.xfer(16'h0100, r);
    chk("readback", {fixed_status, 8'hf0}, r);
    host.xfer(16'h0300, r);
    chk("register readback", {fixed_status, reg_rdata}, r);
    host.xfer(16'h0180, r);
    chk("device id", {fixed_status, id_io_state}, r);
    for (int s = 0; s < 2; s++)
    begin
      host.xfer({7'h72, 1'b1, 1'(s), 7'h00}, r);
      chk("flags", {fixed_status, flags_rdata}, r);
      chk("flag sel", 16'({5'h12, 1'(s)}), 16'({reg_addr, flag_sub_high}));
    end
    chk("flag strobes", 16'd2, 16'(n_fl));
    host.xfer(16'h8080, r);
    chk("reserved", {fixed_status, 8'h00}, r);
    $display("test reads done");
    misc_init = 8'h40;
    wr(5'h00, 8'h28, par({7'h20, 1'b0, 8'h28}));
    chk("good parity", 16'h0028, 16'(amr));
    wr(5'h00, 8'h48, ~par({7'h20, 1'b0, 8'h48}));
    chk("bad parity", 16'h0028, 16'(amr));
    chk("parity error", 16'd1, 16'(n_pe));
    chk("write count", 16'd10, 16'(n_wr));
    $display("test parity done");
    misc_init = 8'h00;
    normal_mode = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk("left normal", 16'h0000, 16'(amr));
    normal_mode = 1'b1;
    wr(5'h00, 8'h60, 1'b0);
    chk("back to normal", 16'h0060, 16'(amr));
    can_reg_on = 1'b0;
    wr(5'h00, 8'h60, 1'b0);
    chk("regulator off", 16'h0000, 16'(amr));
    host.xfer(16'h0100, r);
    chk("off readback", {fixed_status, 8'h00}, r);
    $display("test regulator done");
    complete_run();
  end
endmodule : test_spi_command_frame_decoder
